/* logic/tya_pkg.sv */
// package for the t1 remote alarm generator: offsets, fields, constants
// assumes a transmit framer that pulses once per frame and per data-link bit
package tya_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses on the avalon slave)
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h108;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h10c;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam int RULE_BIT = 7;
	localparam int ENABLE_BIT = 6;
	localparam int SEL_MSB = 5;
	localparam int SEL_LSB = 4;
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_GAP_BIT = 1;
	localparam int STAT_ESF_BIT = 2;

	// ------------------------------------------------------------
	// alarm select codes and patterns
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_LOW = 2'h1;
	localparam logic [1:0] SEL_HIGH = 2'h2;
	localparam logic [1:0] SEL_BOTH = 2'h3;
	localparam logic [15:0] PATTERN_HALF = 16'hff00;
	localparam logic [15:0] PATTERN_ONES = 16'hffff;
	localparam logic [7:0] PATTERN_REPEATS = 8'hff;
	localparam logic [3:0] PATTERN_LAST_BIT = 4'hf;

	// ------------------------------------------------------------
	// timing: one second measured in transmitted frames
	// ------------------------------------------------------------
	localparam int FRAME_RATE_HZ = 8000;
	localparam int ONE_SECOND_S = 1;
	localparam int FRAMES_PER_SECOND = FRAME_RATE_HZ * ONE_SECOND_S;

	// ------------------------------------------------------------
	// framing selector codes
	// ------------------------------------------------------------
	localparam logic [2:0] FS_SF = 3'h5;
	localparam logic [2:0] FS_N = 3'h6;
	localparam logic [2:0] FS_T1DM = 3'h7;

	typedef enum logic [2:0] {FR_ESF, FR_SF, FR_N, FR_T1DM, FR_OTHER} tya_framing_t;
	typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_GAP} tya_mode_t;

	typedef struct packed {
		tya_mode_t mode;
		logic [7:0] ctrl;
		logic lowPrev;
		logic [7:0] patCount;
		logic [3:0] bitIdx;
		logic forceBit2;
		logic forceYLow;
		logic fsOne;
		logic dlOverride;
		logic dlBit;
		logic onesPattern;
		logic waitrequest;
		logic [31:0] readdata;
	} tya_regs_t;

endpackage : tya_pkg

/* logic/tya_frame_timer.sv */
// frame-count timer: restarts on start, raises done after count whole frames
// assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/10ps
`default_nettype none
module tya_frame_timer #(
	parameter int COUNT = 8000,
	parameter int W = $clog2(COUNT + 1)
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic tick,
	input wire logic start,
	output logic done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} tya_tmr_t;

	tya_tmr_t st;
	tya_tmr_t next_st;

	// ------------------------------------------------------------
	// counting
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (start) begin
			next_st.cnt = '0;
			next_st.done = 1'b0;
		end else if (tick && !st.done) begin
			next_st.cnt = st.cnt + 1'b1;
			// first tick only closes the frame that start fell in
			next_st.done = (st.cnt == W'(COUNT));
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;

endmodule : tya_frame_timer
`default_nettype wire

/* logic/tya_alarm_gen.sv */
// transmit remote alarm generator for one t1 channel, avalon-mm slave
// assumes framing code, frame tick and data-link slot from the framer clock
`timescale 1ns/10ps
`default_nettype none
module tya_alarm_gen
	import tya_pkg::*;
#(
	parameter int FRAMES_PER_SEC = FRAMES_PER_SECOND
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	input wire logic [2:0] framingSelect,
	input wire logic frameTick,
	input wire logic dataLinkSlot,
	output logic forcePayloadBit2,
	output logic forceYBitLow,
	output logic fsFrame12One,
	output logic dataLinkOverride,
	output logic dataLinkBit
);
	tya_regs_t st;
	tya_regs_t next_st;
	tya_framing_t framing;
	logic [1:0] sel;
	logic rule;
	logic enable;
	logic selLow;
	logic want;
	logic rising;
	logic active;
	logic tmrStart;
	logic tmrDone;
	logic [15:0] pattern;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic tya_framing_t decodeFraming(input logic [2:0] code);
		if (!code[2]) begin
			return FR_ESF;
		end else if (code == FS_SF) begin
			return FR_SF;
		end else if (code == FS_N) begin
			return FR_N;
		end else if (code == FS_T1DM) begin
			return FR_T1DM;
		end else begin
			return FR_OTHER;
		end
	endfunction : decodeFraming

	// ------------------------------------------------------------
	// one-second timer, shared by hold and gap
	// ------------------------------------------------------------
	tya_frame_timer #(
		.COUNT(FRAMES_PER_SEC)
	) secondTimer (
		.clock(clock),
		.resetn(resetn),
		.tick(frameTick),
		.start(tmrStart),
		.done(tmrDone)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		framing = decodeFraming(framingSelect);
		rule = st.ctrl[RULE_BIT];
		enable = st.ctrl[ENABLE_BIT];
		sel = st.ctrl[SEL_MSB:SEL_LSB];
		selLow = sel[0];
		tmrStart = 1'b0;

		// duration: the esf count finishes a pulse after select clears
		if (rule) begin
			active = (st.mode == ST_ACTIVE);
		end else if (framing == FR_ESF && st.patCount != 8'h00) begin
			active = 1'b1;
		end else if (sel == SEL_OFF) begin
			active = 1'b0;
		end else if (framing != FR_ESF) begin
			active = 1'b1;
		end else if (sel == SEL_HIGH) begin
			active = 1'b1;
		end else begin
			active = selLow;
		end

		// bus slave: one wait cycle, then the answer
		next_st.waitrequest = !((avsRead || avsWrite) && st.waitrequest);
		if (avsWrite && !st.waitrequest) begin
			if (avsAddress == OFF_CONTROL) begin
				next_st.ctrl = avsWritedata[7:0];
			end
		end
		if (avsRead && st.waitrequest) begin
			if (avsAddress == OFF_CONTROL) begin
				next_st.readdata = {24'h000000, st.ctrl};
			end else if (avsAddress == OFF_STATUS) begin
				next_st.readdata = 32'h00000000;
				next_st.readdata[STAT_ACTIVE_BIT] = active;
				next_st.readdata[STAT_GAP_BIT] = (st.mode == ST_GAP);
				next_st.readdata[STAT_ESF_BIT] = (framing == FR_ESF);
			end else begin
				next_st.readdata = 32'h00000000;
			end
		end

		// enforced rule: enable and a nonzero select set duration, select sets format
		want = rule && enable && (sel != SEL_OFF);
		case (st.mode)
			ST_IDLE: begin
				if (want) begin
					next_st.mode = ST_ACTIVE;
					tmrStart = 1'b1;
					next_st.bitIdx = 4'h0;
				end
			end
			ST_ACTIVE: begin
				if (!rule) begin
					next_st.mode = ST_IDLE;
				end else if (!want && tmrDone) begin
					next_st.mode = ST_GAP;
					tmrStart = 1'b1;
				end
			end
			ST_GAP: begin
				if (!rule || tmrDone) begin
					next_st.mode = ST_IDLE;
				end
			end
			default: begin
				next_st.mode = ST_IDLE;
			end
		endcase

		// low select pulses restart the esf pattern count
		rising = selLow && !st.lowPrev;
		next_st.lowPrev = selLow;
		if (rising && !rule && framing == FR_ESF) begin
			next_st.patCount = PATTERN_REPEATS;
			next_st.bitIdx = 4'h0;
		end else if (dataLinkSlot && st.dlOverride) begin
			next_st.bitIdx = st.bitIdx + 4'h1;
			if (st.bitIdx == PATTERN_LAST_BIT && st.patCount != 8'h00) begin
				next_st.patCount = st.patCount - 8'h01;
			end
		end
		if (selLow) begin
			next_st.onesPattern = (sel == SEL_BOTH);
		end
		// a count left from another framing or the rule would fire later
		if (rule || framing != FR_ESF) begin
			next_st.patCount = 8'h00;
		end

		// format
		next_st.forceBit2 = active && (framing == FR_SF || framing == FR_N)
			&& selLow;
		next_st.fsOne = active && framing == FR_SF && sel == SEL_HIGH;
		next_st.forceYLow = active && framing == FR_T1DM;
		next_st.dlOverride = active && framing == FR_ESF;
		// after a short pulse select reads 00, so the format is remembered
		pattern = (sel == SEL_BOTH || (!rule && sel == SEL_OFF
			&& st.onesPattern)) ? PATTERN_ONES : PATTERN_HALF;
		next_st.dlBit = next_st.dlOverride
			&& pattern[PATTERN_LAST_BIT - next_st.bitIdx];
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.ctrl <= CONTROL_RESET;
			st.mode <= ST_IDLE;
			st.waitrequest <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign avsReaddata = st.readdata;
	assign avsWaitrequest = st.waitrequest;
	assign forcePayloadBit2 = st.forceBit2;
	assign forceYBitLow = st.forceYLow;
	assign fsFrame12One = st.fsOne;
	assign dataLinkOverride = st.dlOverride;
	assign dataLinkBit = st.dlBit;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	sequence holding;
		rule && st.mode == ST_ACTIVE && !tmrDone;
	endsequence

	sequence gapping;
		rule && st.mode == ST_GAP && !tmrDone;
	endsequence

	a_hold_min: assert property (holding |=> st.mode == ST_ACTIVE)
		else $error("alarm ended before one second");
	a_gap_min: assert property (gapping |=> st.mode == ST_GAP)
		else $error("alarm restarted inside the gap");
	a_enable_stop: assert property (
		rule && st.mode == ST_ACTIVE && !enable && tmrDone
		|=> st.mode == ST_GAP ##1 !forceYBitLow && !dataLinkOverride)
		else $error("alarm did not stop on enable low");
	a_rule_select_off: assert property (
		rule && st.mode == ST_IDLE && sel == SEL_OFF |=> st.mode == ST_IDLE)
		else $error("alarm began with select off");
	a_no_gap: assert property (!rule |=> st.mode == ST_IDLE)
		else $error("gap state used without the rule");
	a_enable_ignored: assert property (
		!rule && !enable && sel == SEL_LOW && framing == FR_N
		|=> forcePayloadBit2)
		else $error("alarm needed enable without the rule");
	a_select_off: assert property (
		!rule && sel == SEL_OFF && st.patCount == 8'h00
		|=> !forcePayloadBit2 && !forceYBitLow
		&& !fsFrame12One && !dataLinkOverride)
		else $error("alarm sent with select off");
	a_ybit_low: assert property (
		!rule && sel == SEL_HIGH && framing == FR_T1DM |=> forceYBitLow)
		else $error("y bit not forced");
	a_fs_frame12: assert property (
		!rule && sel == SEL_HIGH && framing == FR_SF
		|=> fsFrame12One && !forcePayloadBit2)
		else $error("fs bit alarm wrong");
	a_count_restart: assert property (
		!rule && rising && framing == FR_ESF
		|=> st.patCount == PATTERN_REPEATS)
		else $error("pattern count not restarted");
	a_esf_high: assert property (
		!rule && sel == SEL_HIGH && framing == FR_ESF |=> dataLinkOverride)
		else $error("esf alarm not following high bit");
	a_burst_runs: assert property (
		!rule && framing == FR_ESF && st.patCount != 8'h00
		|=> dataLinkOverride)
		else $error("esf burst cut short");
	a_ones_pattern: assert property (
		$past(sel) == SEL_BOTH && dataLinkOverride |-> dataLinkBit)
		else $error("sixteen ones pattern broken");

endmodule : tya_alarm_gen
`default_nettype wire

/* bench/tya_far_end.sv */
// far-side model: framer timing pulses and capture of the data-link bits
// assumes the generator's clock and its active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module tya_far_end (
	input wire logic clock,
	input wire logic resetn,
	input wire logic clear,
	input wire logic dataLinkOverride,
	input wire logic dataLinkBit,
	output logic frameTick,
	output logic dataLinkSlot,
	output logic [15:0] rxPattern,
	output logic [15:0] rxCount
);
	// ------------------------------------------------------------
	// frame every 16 cycles, data-link slot every 4: far faster than
	// real line rates so a whole alarm fits a short run
	// ------------------------------------------------------------
	logic [3:0] phase;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			phase <= 4'h0;
			frameTick <= 1'b0;
			dataLinkSlot <= 1'b0;
			rxPattern <= 16'h0000;
			rxCount <= 16'h0000;
		end else begin
			phase <= phase + 4'h1;
			frameTick <= (phase == 4'hf);
			dataLinkSlot <= (phase[1:0] == 2'h1);
			if (clear) begin
				rxPattern <= 16'h0000;
				rxCount <= 16'h0000;
			end else if (dataLinkSlot && dataLinkOverride) begin
				rxPattern <= {rxPattern[14:0], dataLinkBit};
				rxCount <= rxCount + 16'h0001;
			end
		end
	end
endmodule : tya_far_end
`default_nettype wire

/* bench/tya_alarm_gen_test.sv */
// testbench for the remote alarm generator, register calls and checks
// assumes the far-side model supplies frame and data-link timing
`timescale 1ns/10ps
`default_nettype none
module tya_alarm_gen_test;
	import tya_pkg::*;
	logic clock, resetn, avsRead, avsWrite, clear, avsWaitrequest;
	logic [ADDR_W-1:0] avsAddress;
	logic [31:0] avsWritedata, avsReaddata, rd;
	logic [2:0] framingSelect;
	logic frameTick, dataLinkSlot, dataLinkOverride, dataLinkBit;
	logic forcePayloadBit2, forceYBitLow, fsFrame12One;
	logic [15:0] rxPattern, rxCount;
	int err_total, total_checks, ticks, t0;
	logic [2:0] fsT [11] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6,
		3'h7, 3'h7, 3'h7, 3'h4};
	logic [7:0] cT [11] = '{8'h10, 8'h30, 8'h20, 8'h00, 8'h40, 8'h10,
		8'h30, 8'h10, 8'h20, 8'h30, 8'h10};
	logic [2:0] oT [11] = '{3'h4, 3'h4, 3'h1, 3'h0, 3'h0, 3'h4, 3'h4,
		3'h2, 3'h2, 3'h2, 3'h0};
	tya_alarm_gen #(.FRAMES_PER_SEC(8)) tya_alarm_gen_inst (.clock(clock),
		.resetn(resetn), .avsAddress(avsAddress), .avsRead(avsRead),
		.avsWrite(avsWrite), .avsWritedata(avsWritedata),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
		.framingSelect(framingSelect), .frameTick(frameTick),
		.dataLinkSlot(dataLinkSlot), .forcePayloadBit2(forcePayloadBit2),
		.forceYBitLow(forceYBitLow), .fsFrame12One(fsFrame12One),
		.dataLinkOverride(dataLinkOverride), .dataLinkBit(dataLinkBit));
	tya_far_end tya_far_end_inst (.clock(clock), .resetn(resetn),
		.clear(clear), .dataLinkOverride(dataLinkOverride),
		.dataLinkBit(dataLinkBit), .frameTick(frameTick),
		.dataLinkSlot(dataLinkSlot), .rxPattern(rxPattern),
		.rxCount(rxCount));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	always @(posedge clock) if (frameTick === 1'b1) ticks <= ticks + 1;
	task automatic chk(input string nm, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic bus(input logic isW, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clock);
		avsAddress <= a;
		avsWrite <= isW;
		avsRead <= !isW;
		avsWritedata <= d;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (avsWaitrequest !== 1'b0 && k < 40);
		if (k >= 40) chk("bus answer", 0, 1);
		rd = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] d);
		bus(1'b1, OFF_CONTROL, {24'h0, d});
		repeat (3) @(posedge clock);
	endtask : wr
	function automatic logic sig(input int w);
		return (w == 0) ? fsFrame12One : dataLinkOverride;
	endfunction : sig
	task automatic waitFor(input int w, input logic v, input int lim);
		int k;
		k = 0;
		while (sig(w) !== v && k < lim) begin
			@(posedge clock);
			k++;
		end
		if (k >= lim) chk("output wait", w, 99);
	endtask : waitFor
	task print_verdict;
		if (err_total == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	// ------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (90000) @(posedge clock);
		err_total++;
		print_verdict();
	end
	initial begin
		resetn = 1'b0;
		{avsRead, avsWrite, clear, ticks} = '0;
		avsAddress = '0;
		avsWritedata = '0;
		framingSelect = 3'h4;
		err_total = 0;
		total_checks = 0;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		bus(1'b0, OFF_CONTROL, 0);
		chk("control reset", rd, 32'h0);
		chk("outputs reset", {forcePayloadBit2, forceYBitLow,
			fsFrame12One, dataLinkOverride}, 0);
		bus(1'b1, OFF_CONTROL, 32'ha5);
		bus(1'b0, OFF_CONTROL, 0);
		chk("control readback", rd, 32'ha5);
		bus(1'b0, 12'h200, 0);
		chk("unmapped read", rd, 32'h0);
		// no rule: select alone sets format per framing
		for (int i = 0; i < 11; i++) begin
			framingSelect <= fsT[i];
			wr(cT[i]);
			chk("format", {forcePayloadBit2, forceYBitLow, fsFrame12One},
				oT[i]);
		end
		framingSelect <= 3'h0;
		wr(8'h20);
		chk("esf held", dataLinkOverride, 1);
		wr(8'h00);
		chk("esf released", dataLinkOverride, 0);
		// short pulse on the low select bit: whole 255-pattern burst
		for (int j = 0; j < 2; j++) begin
			clear <= 1'b1;
			@(posedge clock);
			clear <= 1'b0;
			bus(1'b1, OFF_CONTROL, j ? 32'h30 : 32'h10);
			bus(1'b1, OFF_CONTROL, 32'h0);
			waitFor(1, 1'b0, 20000);
			chk("burst bits", rxCount, 16'h0ff0);
			chk("burst pattern", rxPattern,
				j ? 16'hffff : 16'hff00);
		end
		// long hold outlasts the count; a second pulse restarts it
		wr(8'h10);
		repeat (16400) @(posedge clock);
		chk("held past count", dataLinkOverride, 1);
		wr(8'h00);
		chk("held released", dataLinkOverride, 0);
		wr(8'h10);
		wr(8'h00);
		repeat (8000) @(posedge clock);
		wr(8'h10);
		wr(8'h00);
		repeat (9000) @(posedge clock);
		chk("pulse restarts count", dataLinkOverride, 1);
		waitFor(1, 1'b0, 20000);
		framingSelect <= 3'h5;
		wr(8'hc0);
		chk("rule sel off", {forcePayloadBit2, fsFrame12One}, 0);
		wr(8'he0);
		waitFor(0, 1'b1, 10);
		t0 = ticks;
		chk("format only", forcePayloadBit2, 0);
		wr(8'ha0);
		waitFor(0, 1'b0, 400);
		chk("min length", (ticks - t0 >= 8) && (ticks - t0 <= 9), 1);
		t0 = ticks;
		wr(8'he0);
		waitFor(0, 1'b1, 400);
		chk("min gap", (ticks - t0 >= 8) && (ticks - t0 <= 10), 1);
		print_verdict();
	end
endmodule : tya_alarm_gen_test
`default_nettype wire
